// [rtl/timebase_if.sv]
// Purpose: Carries the time-base request and tick between the two modules
// Assumes: Same clock domain on both sides
// Notes: Control side drives enables, generator side returns the tick
interface timebase_if;
   logic ce;
   logic run;
   logic restart;
   logic [1:0] code;
   logic tick;
   modport ctl (output ce, output run, output restart, output code, input tick);
   modport gen (input ce, input run, input restart, input code, output tick);
endinterface

// [rtl/wdog_pkg.sv]
// Purpose: Constants and types shared by the window watchdog files
// Assumes: One 100 MHz clock, asynchronous active-low reset
// Notes: Register bus is a simple single-cycle peripheral port
package wdog_pkg;
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] CFG_OFS = 4'h4;
   localparam logic [3:0] STS_OFS = 4'h8;
   localparam int COUNT_LSB = 0;
   localparam int EN_BIT = 7;
   localparam int WINDOW_LSB = 0;
   localparam int TB_LSB = 7;
   localparam int IRQ_EN_BIT = 9;
   localparam int FLAG_BIT = 0;
   localparam logic [6:0] COUNT_RESET = 7'h7f;
   localparam logic [6:0] WINDOW_RESET = 7'h7f;
   localparam logic [6:0] EARLY_VAL = 7'h40;
   localparam logic [6:0] EARLY_PRE = 7'h41;
   localparam int PRE_DIV = 4096;
   localparam int CLOCK_HZ = 100000000;

   typedef struct packed {
      logic [6:0] down_counter_value;
      logic watchdog_enable_bit;
      logic [6:0] window_value;
      logic [1:0] time_base;
      logic early_warning_int_enable;
      logic early_warning_flag;
      logic wdog_reset;
      logic early_irq;
      logic [31:0] rdata;
   } wdog_s;

   typedef struct packed {
      logic [14:0] div_cnt;
      logic tick;
   } timebase_s;

   // Terminal count of the prescaler for a given time-base code
   function automatic logic [14:0] tb_limit(input logic [1:0] code);
      tb_limit = 15'((PRE_DIV << code) - 1);
   endfunction

   // Register hit: offset matches and access lands on the low half-word
   function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] ofs);
      reg_hit = (addr[3:2] == ofs[3:2]) && !addr[1];
   endfunction
endpackage

// [rtl/wdog_timebase.sv]
// Purpose: Prescaler producing one tick per 4096 << code clocks
// Assumes: Clock is the peripheral bus clock
// Notes: Restart keeps a fresh reload from losing part of a period
module wdog_timebase
   import wdog_pkg::*;
(
   input wire logic clock, // Bus clock
   input wire logic nrst, // Async reset, active low
   timebase_if.gen tb // Control and tick
);
   timebase_s st_reg;
   timebase_s st_next;

   always_comb begin
      st_next = st_reg;
      if (tb.ce) begin
         st_next.tick = 1'b0;
         if (!tb.run || tb.restart) begin
            st_next.div_cnt = '0;
         end else if (st_reg.div_cnt >= tb_limit(tb.code)) begin
            st_next.div_cnt = '0;
            st_next.tick = 1'b1;
         end else begin
            st_next.div_cnt = st_reg.div_cnt + 15'h0001;
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tb.tick = st_reg.tick;

   a_tick_single: assert property (@(posedge clock) disable iff (!nrst)
      tb.ce && st_reg.tick |=> !st_reg.tick)
      else $error("time-base tick lasted more than one cycle");

   a_tick_at_limit: assert property (@(posedge clock) disable iff (!nrst)
      tb.ce && tb.run && !tb.restart && st_reg.div_cnt == tb_limit(tb.code) |=> st_reg.tick)
      else $error("no time-base tick at terminal count");

   a_div_held: assert property (@(posedge clock) disable iff (!nrst)
      tb.ce && !tb.run |=> st_reg.div_cnt == 15'h0000 && !st_reg.tick)
      else $error("prescaler ran while disabled");
endmodule

// [rtl/window_watchdog_unit.sv]
// Purpose: Window watchdog with early warning and register port
// Assumes: Register requests are single-cycle strobes, read data next cycle
// Notes: Watchdog reset output holds until the system reset clears it
module window_watchdog_unit
   import wdog_pkg::*;
(
   input wire logic clock, // Peripheral bus clock
   input wire logic nrst, // Async reset, active low
   input wire logic clk_en, // Freezes all state when low
   input wire logic reg_sel, // Access strobe
   input wire logic reg_write, // 1 write, 0 read
   input wire logic reg_half, // 1 half-word, 0 word
   input wire logic [3:0] reg_addr, // Byte address
   input wire logic [31:0] reg_wdata, // Write data
   output logic [31:0] reg_rdata, // Read data, one cycle later
   output logic wdog_reset, // Watchdog system reset request
   output logic early_irq // Early-warning interrupt
);
   wdog_s st_reg;
   wdog_s st_next;
   timebase_if tbi ();
   logic wr_ctrl;
   logic wr_cfg;
   logic wr_sts;
   logic step;

   wdog_timebase u_timebase (
      .clock(clock),
      .nrst(nrst),
      .tb(tbi.ctl)
   );

   // Upper half-word of every register is reserved, so a half access there is a no-op
   assign wr_ctrl = reg_sel && reg_write && reg_hit(reg_addr, CTRL_OFS);
   assign wr_cfg = reg_sel && reg_write && reg_hit(reg_addr, CFG_OFS);
   assign wr_sts = reg_sel && reg_write && reg_hit(reg_addr, STS_OFS);
   assign step = st_reg.watchdog_enable_bit && tbi.tick;

   assign tbi.ce = clk_en;
   assign tbi.run = st_reg.watchdog_enable_bit;
   assign tbi.restart = wr_ctrl;
   assign tbi.code = st_reg.time_base;

   always_comb begin
      st_next = st_reg;
      if (clk_en) begin
         if (step) begin
            st_next.down_counter_value = st_reg.down_counter_value - 7'h01;
            if (st_reg.down_counter_value == EARLY_VAL) begin
               st_next.wdog_reset = 1'b1;
            end
         end
         if (wr_ctrl) begin
            st_next.down_counter_value = reg_wdata[COUNT_LSB +: 7];
            if (reg_wdata[EN_BIT]) begin
               st_next.watchdog_enable_bit = 1'b1;
            end
            if (st_reg.watchdog_enable_bit &&
                st_reg.down_counter_value > st_reg.window_value) begin
               st_next.wdog_reset = 1'b1;
            end
         end
         if (wr_cfg) begin
            st_next.window_value = reg_wdata[WINDOW_LSB +: 7];
            st_next.time_base = reg_wdata[TB_LSB +: 2];
            if (reg_wdata[IRQ_EN_BIT]) begin
               st_next.early_warning_int_enable = 1'b1;
            end
         end
         if (wr_sts && !reg_wdata[FLAG_BIT]) begin
            st_next.early_warning_flag = 1'b0;
         end
         // Set after clear so a coinciding event is not lost
         if (step && st_reg.down_counter_value == EARLY_PRE) begin
            st_next.early_warning_flag = 1'b1;
         end
         st_next.early_irq = st_next.early_warning_flag &&
                             st_next.early_warning_int_enable;
         st_next.rdata = '0;
         if (reg_sel && !reg_write) begin
            if (reg_hit(reg_addr, CTRL_OFS)) begin
               st_next.rdata[COUNT_LSB +: 7] = st_reg.down_counter_value;
               st_next.rdata[EN_BIT] = st_reg.watchdog_enable_bit;
            end else if (reg_hit(reg_addr, CFG_OFS)) begin
               st_next.rdata[WINDOW_LSB +: 7] = st_reg.window_value;
               st_next.rdata[TB_LSB +: 2] = st_reg.time_base;
               st_next.rdata[IRQ_EN_BIT] = st_reg.early_warning_int_enable;
            end else if (reg_hit(reg_addr, STS_OFS)) begin
               st_next.rdata[FLAG_BIT] = st_reg.early_warning_flag;
            end
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         st_reg <= '0;
         st_reg.down_counter_value <= COUNT_RESET;
         st_reg.window_value <= WINDOW_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata = st_reg.rdata;
   assign wdog_reset = st_reg.wdog_reset;
   assign early_irq = st_reg.early_irq;

   a_wrap_reset: assert property (@(posedge clock) disable iff (!nrst)
      clk_en && step && st_reg.down_counter_value == EARLY_VAL |=> wdog_reset)
      else $error("no watchdog reset on step from 0x40");

   a_reset_needs_en: assert property (@(posedge clock) disable iff (!nrst)
      wdog_reset |-> st_reg.watchdog_enable_bit)
      else $error("watchdog reset while disabled");

   a_enable_sticky: assert property (@(posedge clock) disable iff (!nrst)
      st_reg.watchdog_enable_bit |=> st_reg.watchdog_enable_bit)
      else $error("enable bit cleared without reset");

   a_irq_en_sticky: assert property (@(posedge clock) disable iff (!nrst)
      st_reg.early_warning_int_enable |=> st_reg.early_warning_int_enable)
      else $error("interrupt enable cleared without reset");

   a_flag_set: assert property (@(posedge clock) disable iff (!nrst)
      clk_en && step && st_reg.down_counter_value == EARLY_PRE
      |=> st_reg.early_warning_flag && st_reg.down_counter_value == EARLY_VAL)
      else $error("early-warning flag not set at 0x40");

   a_flag_hold: assert property (@(posedge clock) disable iff (!nrst)
      st_reg.early_warning_flag && !(clk_en && wr_sts && !reg_wdata[FLAG_BIT])
      |=> st_reg.early_warning_flag)
      else $error("early-warning flag lost without a zero write");

   a_irq_follow: assert property (@(posedge clock) disable iff (!nrst)
      clk_en |=> early_irq == (st_reg.early_warning_flag &&
                               st_reg.early_warning_int_enable))
      else $error("interrupt does not follow flag and enable");

   a_late_refresh: assert property (@(posedge clock) disable iff (!nrst)
      clk_en && wr_ctrl && st_reg.watchdog_enable_bit &&
      st_reg.down_counter_value > st_reg.window_value |=> wdog_reset)
      else $error("refresh above window did not reset");

   a_reload_value: assert property (@(posedge clock) disable iff (!nrst)
      clk_en && wr_ctrl |=> st_reg.down_counter_value == $past(reg_wdata[6:0]))
      else $error("counter not reloaded by write");

   a_tick_step: assert property (@(posedge clock) disable iff (!nrst)
      clk_en && step && !wr_ctrl
      |=> st_reg.down_counter_value == $past(st_reg.down_counter_value) - 7'h01)
      else $error("counter did not step on tick");

   // Register port read-back, writes and reserved space
   a_ctrl_read: assert property (@(posedge clock) disable iff (!nrst)
      clk_en && reg_sel && !reg_write && reg_hit(reg_addr, CTRL_OFS)
      |=> reg_rdata == {24'h000000, $past(st_reg.watchdog_enable_bit),
                        $past(st_reg.down_counter_value)})
      else $error("control read data wrong");

   a_cfg_read: assert property (@(posedge clock) disable iff (!nrst)
      clk_en && reg_sel && !reg_write && reg_hit(reg_addr, CFG_OFS)
      |=> reg_rdata == {22'h000000, $past(st_reg.early_warning_int_enable),
                        $past(st_reg.time_base), $past(st_reg.window_value)})
      else $error("configuration read data wrong");

   a_sts_read: assert property (@(posedge clock) disable iff (!nrst)
      clk_en && reg_sel && !reg_write && reg_hit(reg_addr, STS_OFS)
      |=> reg_rdata == {31'h00000000, $past(st_reg.early_warning_flag)})
      else $error("status read data wrong");

   a_unmapped_read: assert property (@(posedge clock) disable iff (!nrst)
      clk_en && reg_sel && !reg_write && (reg_addr[1] || reg_addr[3:2] == 2'h3)
      |=> reg_rdata == 32'h00000000)
      else $error("reserved read returned data");

   a_rdata_idle: assert property (@(posedge clock) disable iff (!nrst)
      clk_en && !(reg_sel && !reg_write) |=> reg_rdata == 32'h00000000)
      else $error("read data stood without a read");

   a_upper_ignored: assert property (@(posedge clock) disable iff (!nrst)
      clk_en && reg_sel && reg_write && reg_addr[1]
      |=> $stable(st_reg.window_value) && $stable(st_reg.time_base) &&
          $stable(st_reg.watchdog_enable_bit))
      else $error("upper half-word write changed state");

   a_window_write: assert property (@(posedge clock) disable iff (!nrst)
      clk_en && wr_cfg |=> st_reg.window_value == $past(reg_wdata[6:0]))
      else $error("window value not written");

   a_tb_write: assert property (@(posedge clock) disable iff (!nrst)
      clk_en && wr_cfg |=> st_reg.time_base == $past(reg_wdata[8:7]))
      else $error("time-base code not written");

   a_enable_set: assert property (@(posedge clock) disable iff (!nrst)
      clk_en && wr_ctrl && reg_wdata[EN_BIT] |=> st_reg.watchdog_enable_bit)
      else $error("enable bit not set by write");

   // Sticky, freeze, flag and interrupt behaviour
   a_reset_sticky: assert property (@(posedge clock) disable iff (!nrst)
      wdog_reset |=> wdog_reset)
      else $error("watchdog reset request dropped");

   a_state_frozen: assert property (@(posedge clock) disable iff (!nrst)
      !clk_en |=> st_reg == $past(st_reg))
      else $error("state changed while clock enable low");

   a_no_step_off: assert property (@(posedge clock) disable iff (!nrst)
      clk_en && !st_reg.watchdog_enable_bit && !wr_ctrl
      |=> $stable(st_reg.down_counter_value))
      else $error("counter moved while disabled");

   a_flag_hw_only: assert property (@(posedge clock) disable iff (!nrst)
      clk_en && !st_reg.early_warning_flag &&
      !(step && st_reg.down_counter_value == EARLY_PRE)
      |=> !st_reg.early_warning_flag)
      else $error("early-warning flag set without reaching 0x40");

   a_flag_clear: assert property (@(posedge clock) disable iff (!nrst)
      clk_en && wr_sts && !reg_wdata[FLAG_BIT] &&
      !(step && st_reg.down_counter_value == EARLY_PRE)
      |=> !st_reg.early_warning_flag)
      else $error("zero write did not clear the flag");

   a_set_wins: assert property (@(posedge clock) disable iff (!nrst)
      clk_en && wr_sts && !reg_wdata[FLAG_BIT] &&
      step && st_reg.down_counter_value == EARLY_PRE
      |=> st_reg.early_warning_flag)
      else $error("clear beat a coinciding flag event");

   a_irq_needs_en: assert property (@(posedge clock) disable iff (!nrst)
      early_irq |-> st_reg.early_warning_int_enable)
      else $error("interrupt raised while its enable is zero");

   a_irq_on_early: assert property (@(posedge clock) disable iff (!nrst)
      clk_en && step && st_reg.down_counter_value == EARLY_PRE &&
      st_reg.early_warning_int_enable |=> early_irq)
      else $error("no interrupt on reaching 0x40");

   // Refresh window
   a_in_window: assert property (@(posedge clock) disable iff (!nrst)
      clk_en && wr_ctrl && st_reg.down_counter_value <= st_reg.window_value &&
      !wdog_reset && !(step && st_reg.down_counter_value == EARLY_VAL)
      |=> !wdog_reset)
      else $error("refresh inside window raised a reset");

   a_enabling_write: assert property (@(posedge clock) disable iff (!nrst)
      clk_en && wr_ctrl && !st_reg.watchdog_enable_bit && !wdog_reset |=> !wdog_reset)
      else $error("enabling write raised a reset");
endmodule

// [verif/window_watchdog_unit_bench.sv]
// Purpose: Self-checking bench for the window watchdog unit
// Assumes: Strobe register port with read data one cycle after the strobe
// Notes: Register model is kept in integers, tick timing checked by count
module window_watchdog_unit_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import wdog_pkg::*;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic clk_en = 1'b1;
   logic reg_sel = 1'b0;
   logic reg_write = 1'b0;
   logic reg_half = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] reg_rdata;
   logic wdog_reset;
   logic early_irq;
   int num_errors = 0;
   int n_tests = 0;
   int m_count, m_en, m_window, m_tb, m_ewi, m_flag, n, lim;
   logic [31:0] v;
   always #5 clock = ~clock;
   window_watchdog_unit dut (.clock(clock), .nrst(nrst), .clk_en(clk_en), .reg_sel(reg_sel),
      .reg_write(reg_write), .reg_half(reg_half), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .wdog_reset(wdog_reset), .early_irq(early_irq));
   task close_out;
      $display("errors %0d comparisons %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task chk_bit(input logic got, input logic exp, input string what);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t %s got %b expected %b", $time, what, got, exp);
      end
   endtask
   // Half-word flag is random: low-half behaviour must not depend on it
   task acc(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rd);
      @(posedge clock);
      reg_sel <= 1'b1;
      reg_write <= wr;
      reg_addr <= a;
      reg_wdata <= d;
      reg_half <= 1'($urandom % 2);
      @(posedge clock);
      reg_sel <= 1'b0;
      #1 rd = reg_rdata;
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] rd;
      acc(1'b1, a, d, rd);
      if (a == CTRL_OFS) begin
         m_count = int'(d[6:0]);
         if (d[7]) m_en = 1;
      end else if (a == CFG_OFS) begin
         m_window = int'(d[6:0]);
         m_tb = int'(d[8:7]);
         if (d[9]) m_ewi = 1;
      end else if (a == STS_OFS && !d[0]) m_flag = 0;
   endtask
   task rd_chk(input logic [3:0] a, input string what);
      logic [31:0] rd;
      int e;
      e = 0;
      if (a == CTRL_OFS) e = (m_en << 7) | m_count;
      else if (a == CFG_OFS) e = (m_ewi << 9) | (m_tb << 7) | m_window;
      else if (a == STS_OFS) e = m_flag;
      acc(1'b0, a, 32'h0, rd);
      chk_val(rd, 32'(e), what);
   endtask
   task do_reset;
      @(posedge clock);
      nrst <= 1'b0;
      repeat (5) @(posedge clock);
      nrst <= 1'b1;
      m_count = 'h7f;
      m_window = 'h7f;
      m_en = 0;
      m_tb = 0;
      m_ewi = 0;
      m_flag = 0;
   endtask
   // Bounded wait on one of the two event outputs
   task wait_out(input logic sel_rst, input int limit);
      n = 0;
      while ((sel_rst ? wdog_reset : early_irq) !== 1'b1 && n < limit) begin
         @(posedge clock);
         #1 n++;
      end
   endtask
   initial begin
      #900000;
      num_errors++;
      $display("ERROR t=%0t watchdog expired", $time);
      close_out;
   end
   initial begin
      void'($urandom(69));
      do_reset;
      rd_chk(CTRL_OFS, "ctrl reset");
      rd_chk(CFG_OFS, "cfg reset");
      rd_chk(STS_OFS, "sts reset");
      rd_chk(4'hc, "unmapped read");
      rd_chk(4'h2, "upper half read");
      $display("test reset values done");
      v = $urandom;
      wr(CTRL_OFS, {25'h0, v[6:0]});
      rd_chk(CTRL_OFS, "counter readback");
      acc(1'b1, 4'h2, 32'hffffffff, v);
      rd_chk(CTRL_OFS, "upper half write ignored");
      wr(CTRL_OFS, 32'h40);
      repeat (4200) @(posedge clock);
      #1 chk_bit(wdog_reset, 1'b0, "reset while disabled");
      rd_chk(CTRL_OFS, "counter frozen while disabled");
      wr(CFG_OFS, 32'h27f);
      wr(CFG_OFS, 32'h0);
      rd_chk(CFG_OFS, "int enable set-only");
      $display("test registers done");
      for (int code = 0; code < 4; code++) begin
         do_reset;
         wr(CFG_OFS, 32'h27f | (code << 7));
         wr(CTRL_OFS, 32'hc1);
         lim = PRE_DIV << code;
         wait_out(1'b0, lim + 50);
         chk_bit(n >= lim - 2 && n <= lim + 6, 1'b1, "time base spacing");
         chk_bit(early_irq, 1'b1, "early interrupt");
         m_count = 'h40;
         m_flag = 1;
         rd_chk(CTRL_OFS, "counter at 0x40");
         rd_chk(STS_OFS, "early flag set");
         @(posedge clock);
         #1 chk_val(reg_rdata, 32'h0, "read data cleared");
         if (code == 0) begin
            wr(STS_OFS, 32'h1);
            rd_chk(STS_OFS, "flag write one");
            wr(STS_OFS, 32'h0);
            rd_chk(STS_OFS, "flag write zero");
            chk_bit(wdog_reset, 1'b0, "no reset at 0x40");
            wait_out(1'b1, PRE_DIV + 10);
            chk_bit(wdog_reset, 1'b1, "reset at 0x3f");
            m_count = 'h3f;
            rd_chk(CTRL_OFS, "counter at 0x3f");
         end
         $display("test time base %0d done", code);
      end
      do_reset;
      wr(CFG_OFS, 32'h50);
      wr(CTRL_OFS, 32'hd0);
      wr(CTRL_OFS, 32'h50);
      rd_chk(CTRL_OFS, "enable not cleared");
      wr(CTRL_OFS, 32'h7f);
      chk_bit(wdog_reset, 1'b0, "refresh inside window");
      wr(CTRL_OFS, 32'h7f);
      rd_chk(CTRL_OFS, "reload done");
      chk_bit(wdog_reset, 1'b1, "refresh above window");
      $display("test window refresh done");
      // Clock enable low must freeze counter, prescaler and register port
      do_reset;
      wr(CFG_OFS, 32'h7f);
      wr(CTRL_OFS, 32'hc1);
      @(posedge clock);
      clk_en <= 1'b0;
      acc(1'b1, CTRL_OFS, 32'h7f, v);
      repeat (PRE_DIV + 100) @(posedge clock);
      clk_en <= 1'b1;
      rd_chk(CTRL_OFS, "counter frozen by clock enable");
      rd_chk(STS_OFS, "no flag while frozen");
      repeat (PRE_DIV + 20) @(posedge clock);
      #1 chk_bit(early_irq, 1'b0, "no interrupt while disabled");
      m_count = 'h40;
      m_flag = 1;
      rd_chk(STS_OFS, "flag set without interrupt");
      rd_chk(CTRL_OFS, "counter resumed after freeze");
      $display("test clock enable done");
      close_out;
   end
endmodule
